// ---- rtl/hub_link_if.sv ----
`timescale 1ns/1ps
interface hub_link_if;
  import sensor_hub_pkg::*;
  logic req_valid;          // One-cycle parameter request
  logic req_write;          // High for a write
  param_kind_e req_kind;    // Parameter page
  logic [7:0] req_sensor;   // Sensor identifier
  logic [63:0] req_wdata;   // 8-byte write word
  logic rsp_valid;          // One-cycle answer
  logic [127:0] rsp_rdata;  // Read word, zero after a write
  logic flush_valid;        // One-cycle flush register write
  logic [7:0] flush_id;     // Target identifier or flush-all
  modport device(input req_valid, req_write, req_kind, req_sensor,
    req_wdata, flush_valid, flush_id, output rsp_valid, rsp_rdata);
  modport host(output req_valid, req_write, req_kind, req_sensor,
    req_wdata, flush_valid, flush_id, input rsp_valid, rsp_rdata);
endinterface : hub_link_if

// ---- rtl/rate_ticker.sv ----
`timescale 1ns/1ps
module rate_ticker #(
  parameter int CLK_HZ = 10_000_000
) (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic [15:0] rate_in,
  output logic tick_out
);
  // Accumulator holds cycles-since-tick times rate
  logic [25:0] acc;
  logic [25:0] next_acc;
  logic next_tick;
  logic [25:0] sum;

  // Refuse clocks the accumulator cannot hold or that break the band
  if (CLK_HZ >= (1 << 25) || CLK_HZ < 2 * 65535) begin : g_bad
    $error("rate_ticker: CLK_HZ out of range");
  end

  // Fire after floor(CLK/rate) cycles: never longer than asked, and
  // because rate is far below CLK/2 never shorter than half of it
  always_comb begin
    sum = acc + {10'h000, rate_in};
    next_acc = sum;
    next_tick = 1'b0;
    if (rate_in == 16'h0000) begin
      next_acc = 26'h0000000;
    end else if (sum + {10'h000, rate_in} > 26'(CLK_HZ)) begin
      next_tick = 1'b1;
      next_acc = 26'h0000000;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      acc <= 26'h0000000;
      tick_out <= 1'b0;
    end else begin
      acc <= next_acc;
      tick_out <= next_tick;
    end
  end
endmodule : rate_ticker

// ---- rtl/sensor_hub_device.sv ----
`timescale 1ns/1ps
// Summary of operation
// - Sample rate 16-bit hertz, zero disables
// - Wake and ordinary rates stored separately
// - Latency 16-bit ms, zero means no batching
// - Host pairs non-zero latency with non-zero rate
// - Wake and ordinary latencies stored separately
// - Identifier bit five selects wake variant
// - Sensitivity and range held per sensor
// - Sample period within half to full request
// - Rate and latency share one 8-byte write
// - Rate read returns the applied values
// - Absent sensor reads zero rate, latency
// - Flush uses one 8-bit register
// - Flush sends batch, then completion marker
// - Only wake sensors interrupt, separate FIFOs
// - Static record fields and widths
// - Reserved slots zero, capacity bytes per sample
// - Status byte flags and power mode
// - Status changes live, record stays fixed
// - Record is 15 bytes plus sample size
// - Absent sensor record and power mode zero
// - Scalar packet encodings
// - Uncalibrated vector packet fields
module sensor_hub_device #(
  parameter int MS_CYCLES = sensor_hub_pkg::MS_CYCLES_DEF,
  parameter logic [63:0] PRESENT = sensor_hub_pkg::PRESENT_DEF,
  parameter int FIFO_BYTES = sensor_hub_pkg::FIFO_BYTES_DEF
) (
  input wire logic clock_in,
  input wire logic resetn_in,
  hub_link_if.device link,
  input wire logic fault_valid_in,
  input wire logic [7:0] fault_sensor_in,
  input wire logic [1:0] fault_kind_in,
  output logic [1:0] report_out,
  output logic [1:0] release_out,
  output logic [1:0][15:0] release_count_out,
  output logic host_irq_out,
  output logic flush_done_out,
  output logic [7:0] flush_done_id_out
);
  import sensor_hub_pkg::*;

  // Refuse settings the counters cannot hold, before any cycle runs
  if (MS_CYCLES < 1 || FIFO_BYTES < 16 || FIFO_BYTES > 65535) begin : g_bad
    $error("sensor_hub_device: bad parameter");
  end

  // Per-sensor settings, indexed by the full identifier, so the wake
  // variant (bit five) is a separate entry
  logic [15:0] rate_mem [NUM_IDS];
  logic [15:0] lat_mem [NUM_IDS];
  logic [15:0] sens_mem [NUM_IDS];
  logic [15:0] range_mem [NUM_IDS];
  logic [ST_FLAGS-1:0] stat [NUM_IDS];
  logic [ST_FLAGS-1:0] next_stat [NUM_IDS];
  // Batch state per FIFO: 0 ordinary, 1 wake
  logic [1:0][15:0] pend, next_pend;
  logic [1:0][15:0] timer, next_timer;
  logic [1:0] rel, smp, fhit;
  logic [1:0] next_report;
  logic next_irq;
  // Millisecond divider
  logic [31:0] ms_cnt, next_ms_cnt;
  logic ms_tick;
  // Flush marker pending one cycle behind the release
  logic flush_q, next_flush_q;
  logic [7:0] flush_id_q, next_flush_id_q;
  // Link decode
  logic [IDX_W-1:0] idx;
  logic in_map, here;
  logic wr_rate, wr_sens;
  logic [127:0] next_rdata;
  logic [4:0] styp;
  logic [15:0] cap;
  pwr_mode_e pwr;

  // Sample sources, one per FIFO, each driven by its sensor's rate
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_tick
      // Ordinary accelerometer for g zero, its wake twin for g one
      localparam logic [IDX_W-1:0] SID = {g == 1, ACCEL_TYPE};
      logic tk;
      rate_ticker #(.CLK_HZ(CLK_HZ)) i_rate_ticker (
        .clock_in(clock_in),
        .resetn_in(resetn_in),
        .rate_in(rate_mem[SID]),
        .tick_out(tk)
      );
      // Zero rate keeps the ticker idle, so a tick means enabled
      assign smp[g] = tk & PRESENT[SID];
    end
  endgenerate

  // Request decode; identifiers above the map are absent
  always_comb begin
    idx = link.req_sensor[IDX_W-1:0];
    in_map = (link.req_sensor < 8'(NUM_IDS));
    here = in_map && PRESENT[idx];
    wr_rate = link.req_valid && link.req_write && here &&
      (link.req_kind == PK_RATE_LAT);
    wr_sens = link.req_valid && link.req_write && here &&
      (link.req_kind == PK_SENS_RANGE);
    styp = idx[4:0];
    // Capacity in samples of this sensor's size
    cap = 16'(FIFO_BYTES / int'(sample_bytes(styp)));
    if (!here) pwr = PWR_SHUTDOWN;
    else if (rate_mem[idx] == 16'h0000) pwr = PWR_STANDBY;
    else pwr = PWR_HIGH;
    next_rdata = 128'h0;
    if (link.req_valid && !link.req_write && here) begin
      unique case (link.req_kind)
        PK_RATE_LAT: begin
          // Applied rate equals the request: ticker period is at most
          // one cycle short, well inside the allowed band
          next_rdata[RATE_LSB +: 16] = rate_mem[idx];
          next_rdata[LAT_LSB +: 16] = lat_mem[idx];
        end
        PK_SENS_RANGE: begin
          next_rdata[SENS_LSB +: 16] = sens_mem[idx];
          next_rdata[RANGE_LSB +: 16] = range_mem[idx];
        end
        PK_INFO: begin
          next_rdata = {sample_bytes(styp), cap, RESERVED_SLOTS,
            MIN_RATE, MAX_RATE, POWER_TENTH_MA, RESOLUTION,
            MAX_RANGE, DRIVER_VER, DRIVER_ID,
            {3'h0, styp}};
        end
        PK_STATUS: begin
          next_rdata[7:0] = {1'b0, pwr, stat[idx]};
        end
      endcase
    end
    // Absent sensors leave next_rdata zero
  end

  // Settings store; absent sensors ignore writes
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      for (int i = 0; i < NUM_IDS; i++) begin
        rate_mem[i] <= CFG_RST;
        lat_mem[i] <= CFG_RST;
        sens_mem[i] <= CFG_RST;
        range_mem[i] <= CFG_RST;
      end
    end else begin
      if (wr_rate) begin
        rate_mem[idx] <= link.req_wdata[RATE_LSB +: 16];
        lat_mem[idx] <= link.req_wdata[LAT_LSB +: 16];
      end
      if (wr_sens) begin
        sens_mem[idx] <= link.req_wdata[SENS_LSB +: 16];
        range_mem[idx] <= link.req_wdata[RANGE_LSB +: 16];
      end
    end
  end

  // Batching, flush and interrupt decisions
  always_comb begin
    next_ms_cnt = ms_cnt + 32'h1;
    ms_tick = (ms_cnt == 32'(MS_CYCLES - 1));
    if (ms_tick) next_ms_cnt = 32'h0;
    next_flush_q = 1'b0;
    next_flush_id_q = flush_id_q;
    fhit = 2'b00;
    if (link.flush_valid && link.flush_id != FLUSH_NOP) begin
      next_flush_q = 1'b1;
      next_flush_id_q = link.flush_id;
      if (link.flush_id == FLUSH_ALL) fhit = 2'b11;
      else if (link.flush_id < 8'(NUM_IDS))
        fhit[link.flush_id[WAKE_BIT]] = 1'b1;
    end
    next_report = 2'b00;
    for (int f = 0; f < 2; f++) begin
      // Expiry of the oldest batched sample, or a flush hit
      rel[f] = (ms_tick && timer[f] == 16'h0001) ||
        (fhit[f] && pend[f] != 16'h0000);
      next_pend[f] = pend[f];
      next_timer[f] = timer[f];
      if (ms_tick && timer[f] != 16'h0000)
        next_timer[f] = timer[f] - 16'h0001;
      if (rel[f]) begin
        next_pend[f] = 16'h0000;
        next_timer[f] = 16'h0000;
      end
      if (smp[f]) begin
        if (lat_mem[{f[0], ACCEL_TYPE}] == 16'h0000) begin
          next_report[f] = 1'b1;
        end else begin
          if (next_pend[f] != 16'(FIFO_BYTES / 8))
            next_pend[f] = next_pend[f] + 16'h0001;
          if (next_timer[f] == 16'h0000)
            next_timer[f] = lat_mem[{f[0], ACCEL_TYPE}];
        end
      end
    end
    // Ordinary FIFO never raises the host line
    next_irq = next_report[1] | rel[1];
  end

  // Status flags NACK to LOST clear on status read, set wins over clear
  always_comb begin
    for (int i = 0; i < NUM_IDS; i++) begin
      next_stat[i] = stat[i];
      if (link.req_valid && !link.req_write && in_map &&
          link.req_kind == PK_STATUS && idx == IDX_W'(i)) begin
        next_stat[i][ST_LOST:ST_NACK] = 4'h0;
      end
    end
    for (int f = 0; f < 2; f++) begin
      if (rel[f] || next_report[f])
        next_stat[{f[0], ACCEL_TYPE}][ST_AVAIL] = 1'b0;
      if (smp[f] && !next_report[f]) begin
        next_stat[{f[0], ACCEL_TYPE}][ST_AVAIL] = 1'b1;
        if (pend[f] == 16'(FIFO_BYTES / 8) && !rel[f])
          next_stat[{f[0], ACCEL_TYPE}][ST_LOST] = 1'b1;
      end
    end
    if (fault_valid_in && fault_sensor_in < 8'(NUM_IDS)) begin
      unique case (fault_kind_in)
        FLT_NACK: next_stat[fault_sensor_in[5:0]][ST_NACK] = 1'b1;
        FLT_IDENT: next_stat[fault_sensor_in[5:0]][ST_IDENT] = 1'b1;
        FLT_TRANS: next_stat[fault_sensor_in[5:0]][ST_TRANS] = 1'b1;
        default: ;
      endcase
    end
  end

  // All state except the settings store, and all outputs, registered here
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      for (int i = 0; i < NUM_IDS; i++) stat[i] <= '0;
      pend <= '0;
      timer <= '0;
      ms_cnt <= 32'h0;
      flush_q <= 1'b0;
      flush_id_q <= 8'h00;
      report_out <= 2'b00;
      release_out <= 2'b00;
      release_count_out <= '0;
      host_irq_out <= 1'b0;
      flush_done_out <= 1'b0;
      flush_done_id_out <= 8'h00;
      link.rsp_valid <= 1'b0;
      link.rsp_rdata <= 128'h0;
    end else begin
      stat <= next_stat;
      pend <= next_pend;
      timer <= next_timer;
      ms_cnt <= next_ms_cnt;
      flush_q <= next_flush_q;
      flush_id_q <= next_flush_id_q;
      report_out <= next_report;
      release_out <= rel;
      release_count_out <= pend;
      host_irq_out <= next_irq;
      // Marker follows the released batch by one cycle
      flush_done_out <= flush_q;
      flush_done_id_out <= flush_id_q;
      link.rsp_valid <= link.req_valid;
      link.rsp_rdata <= next_rdata;
    end
  end
endmodule : sensor_hub_device

// ---- rtl/sensor_hub_host.sv ----
`timescale 1ns/1ps
module sensor_hub_host (
  input wire logic clock_in,
  input wire logic resetn_in,
  hub_link_if.host link,
  input wire logic cmd_valid_in,
  input wire logic cmd_write_in,
  input wire sensor_hub_pkg::param_kind_e cmd_kind_in,
  input wire logic [7:0] cmd_sensor_in,
  input wire logic [63:0] cmd_wdata_in,
  input wire logic flush_valid_in,
  input wire logic [7:0] flush_id_in,
  output logic cmd_ready_out,
  output logic done_out,
  output logic [127:0] rdata_out
);
  import sensor_hub_pkg::*;

  typedef enum logic {H_IDLE, H_WAIT} host_state_e;
  host_state_e state, next_state;
  logic [63:0] wdata;

  // Latency without a rate is forced to zero before sending
  always_comb begin
    wdata = cmd_wdata_in;
    if (cmd_write_in && cmd_kind_in == PK_RATE_LAT &&
        cmd_wdata_in[RATE_LSB +: 16] == 16'h0000)
      wdata[LAT_LSB +: 16] = 16'h0000;
    next_state = state;
    unique case (state)
      H_IDLE: if (cmd_valid_in) next_state = H_WAIT;
      H_WAIT: if (link.rsp_valid) next_state = H_IDLE;
    endcase
  end

  // One request outstanding at a time
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      state <= H_IDLE;
      cmd_ready_out <= 1'b0;
      done_out <= 1'b0;
      rdata_out <= 128'h0;
      link.req_valid <= 1'b0;
      link.req_write <= 1'b0;
      link.req_kind <= PK_RATE_LAT;
      link.req_sensor <= 8'h00;
      link.req_wdata <= 64'h0;
      link.flush_valid <= 1'b0;
      link.flush_id <= 8'h00;
    end else begin
      state <= next_state;
      cmd_ready_out <= (next_state == H_IDLE);
      link.req_valid <= (state == H_IDLE) && cmd_valid_in;
      if (state == H_IDLE && cmd_valid_in) begin
        link.req_write <= cmd_write_in;
        link.req_kind <= cmd_kind_in;
        link.req_sensor <= cmd_sensor_in;
        link.req_wdata <= wdata;
      end
      done_out <= (state == H_WAIT) && link.rsp_valid;
      if (state == H_WAIT && link.rsp_valid)
        rdata_out <= link.rsp_rdata;
      link.flush_valid <= flush_valid_in;
      link.flush_id <= flush_id_in;
    end
  end
endmodule : sensor_hub_host

// ---- rtl/sensor_hub_pkg.sv ----
package sensor_hub_pkg;
  // Core clock and derived millisecond count
  localparam int CLK_HZ = 10_000_000;
  localparam int MS_PER_S = 1000;
  localparam int MS_CYCLES_DEF = CLK_HZ / MS_PER_S;
  // Sensor identifier layout
  localparam int ID_W = 8;
  localparam int IDX_W = 6;
  localparam int NUM_IDS = 64;
  localparam int WAKE_BIT = 5;
  localparam logic [4:0] ACCEL_TYPE = 5'h01;
  localparam logic [63:0] PRESENT_DEF = 64'h0000_0002_0000_0002;
  // Flush register values
  localparam logic [7:0] FLUSH_NOP = 8'h00;
  localparam logic [7:0] FLUSH_ALL = 8'hFF;
  // Parameter pages reachable over the link
  typedef enum logic [1:0] {
    PK_RATE_LAT, PK_SENS_RANGE, PK_INFO, PK_STATUS
  } param_kind_e;
  // Field positions inside the 8-byte parameter word
  localparam int RATE_LSB = 0;
  localparam int LAT_LSB = 32;
  localparam int SENS_LSB = 0;
  localparam int RANGE_LSB = 16;
  localparam logic [15:0] CFG_RST = 16'h0000;
  // Status byte layout
  localparam int ST_AVAIL = 0;
  localparam int ST_NACK = 1;
  localparam int ST_IDENT = 2;
  localparam int ST_TRANS = 3;
  localparam int ST_LOST = 4;
  localparam int ST_PWR_LSB = 5;
  localparam int ST_FLAGS = 5;
  typedef enum logic [1:0] {
    PWR_SHUTDOWN, PWR_STANDBY, PWR_LOW, PWR_HIGH
  } pwr_mode_e;
  // Fault kinds reported by the sensor drivers
  localparam logic [1:0] FLT_NACK = 2'h0;
  localparam logic [1:0] FLT_IDENT = 2'h1;
  localparam logic [1:0] FLT_TRANS = 2'h2;
  // Static information record contents (values arbitrary)
  localparam logic [7:0] DRIVER_ID = 8'h11;
  localparam logic [7:0] DRIVER_VER = 8'h01;
  localparam logic [15:0] MAX_RANGE = 16'h7FFF;
  localparam logic [15:0] RESOLUTION = 16'h0010;
  localparam logic [7:0] POWER_TENTH_MA = 8'h05;
  localparam logic [15:0] MAX_RATE = 16'h00C8;
  localparam logic [7:0] MIN_RATE = 8'h01;
  localparam logic [15:0] RESERVED_SLOTS = 16'h0000;
  localparam int FIFO_BYTES_DEF = 4096;
  // Packet payload encodings
  typedef logic signed [15:0] scalar_t;
  typedef logic [15:0] abs_scalar_t;
  typedef logic [7:0] abs_scalar_short_t;
  typedef logic [23:0] abs_scalar_long_t;
  typedef struct packed {
    logic [15:0] x, y, z, bias_x, bias_y, bias_z;
    logic [7:0] accuracy;
  } vec_uncal_s;
  // FIFO sample size in bytes, identifier byte included
  function automatic logic [7:0] sample_bytes(input logic [4:0] t);
    unique case (t)
      5'd1, 5'd2, 5'd3, 5'd4, 5'd9, 5'd10: sample_bytes = 8'h08;
      5'd11, 5'd15, 5'd20: sample_bytes = 8'h0B;
      5'd14, 5'd16: sample_bytes = 8'h0E;
      5'd6: sample_bytes = 8'h04;
      5'd21: sample_bytes = 8'h02;
      5'd17, 5'd18, 5'd22, 5'd23, 5'd24, 5'd25: sample_bytes = 8'h01;
      default: sample_bytes = 8'h03;
    endcase
  endfunction : sample_bytes
endpackage : sensor_hub_pkg

// ---- verif/hub_link_props.sv ----
`timescale 1ns/1ps
module hub_link_props (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic req_valid,
  input wire logic req_write,
  input wire sensor_hub_pkg::param_kind_e req_kind,
  input wire logic [7:0] req_sensor,
  input wire logic [63:0] req_wdata,
  input wire logic rsp_valid,
  input wire logic [127:0] rsp_rdata,
  input wire logic flush_valid,
  input wire logic [7:0] flush_id
);
  import sensor_hub_pkg::*;
  // One domain, so one clock and one disable for all
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  // Reads of identifiers beyond the map
  logic rd_absent;
  // Reads of the two fitted accelerometer ids
  logic rd_present;
  assign rd_absent = req_valid && !req_write && req_sensor >= 8'h40;
  assign rd_present = req_valid && !req_write &&
    (req_sensor == 8'h01 || req_sensor == 8'h21);
  property p_rsp_next;
    req_valid |=> rsp_valid;
  endproperty
  a_rsp_next: assert property (p_rsp_next)
    else $error("answer missing after request");
  property p_rsp_cause;
    rsp_valid |-> $past(req_valid);
  endproperty
  a_rsp_cause: assert property (p_rsp_cause)
    else $error("answer without request");
  // Host keeps one request outstanding, so a gap follows each
  property p_one_at_time;
    req_valid |=> !req_valid [*2];
  endproperty
  a_one_at_time: assert property (p_one_at_time)
    else $error("requests too close");
  property p_write_zero;
    req_valid && req_write |=> rsp_rdata == '0;
  endproperty
  a_write_zero: assert property (p_write_zero)
    else $error("write answer not zero");
  property p_absent_zero;
    rd_absent && req_kind != PK_SENS_RANGE |=> rsp_rdata == '0;
  endproperty
  a_absent_zero: assert property (p_absent_zero)
    else $error("absent sensor read not zero");
  property p_info_fixed;
    rd_present && req_kind == PK_INFO |=>
      rsp_rdata[103:88] == 16'h0000 && rsp_rdata[127:120] == 8'h08;
  endproperty
  a_info_fixed: assert property (p_info_fixed)
    else $error("info reserved or size wrong");
  property p_present_pwr;
    rd_present && req_kind == PK_STATUS |=> rsp_rdata[6:5] != 2'h0;
  endproperty
  a_present_pwr: assert property (p_present_pwr)
    else $error("present sensor shows no power mode");
  property p_rate_lat_pair;
    req_valid && req_write && req_kind == PK_RATE_LAT &&
      req_wdata[15:0] == 16'h0000 |-> req_wdata[47:32] == 16'h0000;
  endproperty
  a_rate_lat_pair: assert property (p_rate_lat_pair)
    else $error("latency sent with zero rate");
  property p_flush_pulse;
    flush_valid |=> !flush_valid;
  endproperty
  a_flush_pulse: assert property (p_flush_pulse)
    else $error("flush write longer than one cycle");
endmodule : hub_link_props

// ---- verif/sensor_config_status_params_test.sv ----
`timescale 1ns/1ps
`define CHECK(nm, exp, got) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
      fails++; \
      $display("unexpected %s expected %h seen %h", nm, exp, got); \
    end \
  end
module sensor_config_status_params_test;
  import sensor_hub_pkg::*;
  logic clock_in = 1'b0;
  logic resetn_in = 1'b0;
  // Host user side stimulus
  logic cmd_valid = 1'b0;
  logic cmd_write = 1'b0;
  param_kind_e cmd_kind = PK_RATE_LAT;
  logic [7:0] cmd_sensor = 8'h00;
  logic [63:0] cmd_wdata = 64'h0;
  logic flush_valid = 1'b0;
  logic [7:0] flush_id = 8'h00;
  // Sensor driver fault stimulus
  logic fault_valid = 1'b0;
  logic [7:0] fault_sensor = 8'h00;
  logic [1:0] fault_kind = 2'h0;
  logic cmd_ready, done, host_irq, flush_done;
  logic [127:0] rdata, rd;
  logic [1:0] report, release_hit;
  logic [1:0][15:0] release_count;
  logic [7:0] flush_done_id;
  int fails, samples_checked;
  // Static record expected for the accelerometer ids
  logic [127:0] info_exp;
  assign info_exp = {8'h08, 16'(FIFO_BYTES_DEF / 8), 16'h0000, MIN_RATE,
    MAX_RATE, POWER_TENTH_MA, RESOLUTION, MAX_RANGE, DRIVER_VER,
    DRIVER_ID, 8'h01};
  always #50 clock_in = ~clock_in;
  hub_link_if i_hub_link_if ();
  // Short millisecond so latency expiry fits the run
  sensor_hub_device #(.MS_CYCLES(4)) i_sensor_hub_device (
    .clock_in(clock_in), .resetn_in(resetn_in), .link(i_hub_link_if),
    .fault_valid_in(fault_valid), .fault_sensor_in(fault_sensor),
    .fault_kind_in(fault_kind), .report_out(report),
    .release_out(release_hit), .release_count_out(release_count),
    .host_irq_out(host_irq), .flush_done_out(flush_done),
    .flush_done_id_out(flush_done_id));
  sensor_hub_host i_sensor_hub_host (
    .clock_in(clock_in), .resetn_in(resetn_in), .link(i_hub_link_if),
    .cmd_valid_in(cmd_valid), .cmd_write_in(cmd_write),
    .cmd_kind_in(cmd_kind), .cmd_sensor_in(cmd_sensor),
    .cmd_wdata_in(cmd_wdata), .flush_valid_in(flush_valid),
    .flush_id_in(flush_id), .cmd_ready_out(cmd_ready),
    .done_out(done), .rdata_out(rdata));
  hub_link_props i_hub_link_props (
    .clock_in(clock_in), .resetn_in(resetn_in),
    .req_valid(i_hub_link_if.req_valid),
    .req_write(i_hub_link_if.req_write),
    .req_kind(i_hub_link_if.req_kind),
    .req_sensor(i_hub_link_if.req_sensor),
    .req_wdata(i_hub_link_if.req_wdata),
    .rsp_valid(i_hub_link_if.rsp_valid),
    .rsp_rdata(i_hub_link_if.rsp_rdata),
    .flush_valid(i_hub_link_if.flush_valid),
    .flush_id(i_hub_link_if.flush_id));
  // One command: held until taken, then answer captured into rd
  task automatic cmd(input logic wr, input param_kind_e k,
    input logic [7:0] id, input logic [63:0] wd);
    int n;
    n = 0;
    @(negedge clock_in);
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_kind = k;
    cmd_sensor = id;
    cmd_wdata = wd;
    while (cmd_ready !== 1'b1 && n < 20) begin
      @(negedge clock_in);
      n++;
    end
    @(negedge clock_in);
    cmd_valid = 1'b0;
    while (done !== 1'b1 && n < 20) begin
      @(negedge clock_in);
      n++;
    end
    `CHECK("done", 1'b1, done);
    rd = rdata;
    // A command that never finished ends the run here
    if (done !== 1'b1) results();
  endtask : cmd
  task automatic rl(input logic [7:0] id, input logic [15:0] r, l);
    cmd(1'b1, PK_RATE_LAT, id, {16'h0, l, 16'h0, r});
  endtask : rl
  // Counts pulses over a window; a flag may be unknown, so ===
  task automatic watch(input int cyc, output int r0, r1, q, l1);
    {r0, r1, q, l1} = '0;
    repeat (cyc) begin
      @(negedge clock_in);
      r0 += int'(report[0] === 1'b1);
      r1 += int'(report[1] === 1'b1);
      q += int'(host_irq === 1'b1);
      l1 += int'(release_hit[1] === 1'b1);
    end
  endtask : watch
  // Flush write and an eight cycle look at what follows
  task automatic flush(input logic [7:0] id, output logic [1:0] rel,
    output logic irq, fd, output logic [7:0] fid, output logic [15:0] c);
    {rel, irq, fd, fid, c} = '0;
    @(negedge clock_in);
    {flush_valid, flush_id} = {1'b1, id};
    @(negedge clock_in);
    flush_valid = 1'b0;
    repeat (8) begin
      @(negedge clock_in);
      rel |= release_hit;
      irq |= host_irq;
      if (release_hit[0] === 1'b1) c = release_count[0];
      if (flush_done === 1'b1) {fd, fid} = {1'b1, flush_done_id};
    end
  endtask : flush
  task automatic t_rates();
    rl(8'h01, 16'h0064, 16'h0005);
    rl(8'h21, 16'h0032, 16'h0000);
    cmd(1'b0, PK_RATE_LAT, 8'h01, 64'h0);
    `CHECK("rate 1", 16'h0064, rd[15:0]);
    `CHECK("latency 1", 16'h0005, rd[47:32]);
    cmd(1'b0, PK_RATE_LAT, 8'h21, 64'h0);
    `CHECK("rate 33", 16'h0032, rd[15:0]);
    `CHECK("latency 33", 16'h0000, rd[47:32]);
    rl(8'h01, 16'h0000, 16'h0007);
    cmd(1'b0, PK_RATE_LAT, 8'h01, 64'h0);
    `CHECK("latency zero rate", 16'h0000, rd[47:32]);
    cmd(1'b1, PK_SENS_RANGE, 8'h01, 64'hABCD_1234);
    cmd(1'b1, PK_SENS_RANGE, 8'h21, 64'h5678_9ABC);
    cmd(1'b0, PK_SENS_RANGE, 8'h01, 64'h0);
    `CHECK("sens range", 32'hABCD_1234, rd[31:0]);
  endtask : t_rates
  task automatic t_absent();
    param_kind_e ks[3] = '{PK_RATE_LAT, PK_INFO, PK_STATUS};
    rl(8'h40, 16'h000A, 16'h0001);
    foreach (ks[i]) begin
      cmd(1'b0, ks[i], 8'h40, 64'h0);
      `CHECK("absent 64", 128'h0, rd);
      cmd(1'b0, ks[i], 8'h80, 64'h0);
      `CHECK("absent 128", 128'h0, rd);
    end
  endtask : t_absent
  task automatic t_status();
    cmd(1'b0, PK_INFO, 8'h21, 64'h0);
    `CHECK("info 33", info_exp, rd);
    cmd(1'b0, PK_STATUS, 8'h01, 64'h0);
    `CHECK("mode off", 2'h1, rd[6:5]);
    rl(8'h01, 16'h0064, 16'h0000);
    for (int f = 0; f < 3; f++) begin
      @(negedge clock_in);
      {fault_valid, fault_sensor, fault_kind} = {1'b1, 8'h01, 2'(f)};
      @(negedge clock_in);
      fault_valid = 1'b0;
      cmd(1'b0, PK_STATUS, 8'h01, 64'h0);
      `CHECK("fault flag", 4'h1 << f, rd[4:1]);
      `CHECK("mode on", 2'h3, rd[6:5]);
      cmd(1'b0, PK_STATUS, 8'h01, 64'h0);
      `CHECK("flag cleared", 4'h0, rd[4:1]);
    end
    cmd(1'b0, PK_INFO, 8'h01, 64'h0);
    `CHECK("info fixed", info_exp, rd);
  endtask : t_status
  task automatic t_live();
    int n, r0, r1, q, l1;
    logic [1:0] rel;
    logic irq, fd;
    logic [7:0] fid;
    logic [15:0] c;
    rl(8'h01, 16'h2710, 16'h0000);
    n = 0;
    while (report[0] !== 1'b1 && n < 1100) begin
      @(negedge clock_in);
      n++;
    end
    `CHECK("first report", 1'b1, report[0]);
    if (report[0] !== 1'b1) results();
    watch(1, r0, r1, q, l1);
    for (n = 1; n < 1100 && report[0] !== 1'b1; n++) watch(1, r0, r1, q, l1);
    `CHECK("period", 1'b1, n >= 500 && n <= 1000);
    if (n >= 1100) results();
    watch(2100, r0, r1, q, l1);
    `CHECK("ordinary irq", 0, q);
    rl(8'h01, 16'h0000, 16'h0000);
    rl(8'h21, 16'h2710, 16'h0000);
    watch(2100, r0, r1, q, l1);
    `CHECK("disabled", 0, r0);
    `CHECK("wake irq", 1'b1, r1 > 0 && q == r1);
    rl(8'h21, 16'h0000, 16'h0000);
    rl(8'h01, 16'h2710, 16'hFFFF);
    watch(2100, r0, r1, q, l1);
    `CHECK("batched", 0, r0 + q);
    cmd(1'b0, PK_STATUS, 8'h01, 64'h0);
    `CHECK("batch avail", 1'b1, rd[0]);
    rl(8'h01, 16'h0000, 16'h0000);
    flush(8'h01, rel, irq, fd, fid, c);
    `CHECK("flush release", 3'b010, {rel, irq});
    `CHECK("flush count", 1'b1, c != 16'h0000);
    `CHECK("flush marker", 9'h101, {fd, fid});
    flush(FLUSH_NOP, rel, irq, fd, fid, c);
    `CHECK("flush nop", 1'b0, fd);
    rl(8'h21, 16'h2710, 16'h0001);
    watch(2100, r0, r1, q, l1);
    `CHECK("wake expiry", 1'b1, l1 > 0 && q == l1);
    rl(8'h21, 16'h0000, 16'h0000);
    flush(FLUSH_ALL, rel, irq, fd, fid, c);
    `CHECK("flush all", 9'h1FF, {fd, fid});
  endtask : t_live
  task automatic results();
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results
  // Reset for two cycles, then each scenario in turn
  initial begin
    fails = 0;
    samples_checked = 0;
    repeat (2) @(negedge clock_in);
    resetn_in = 1'b1;
    t_rates();
    t_absent();
    t_status();
    t_live();
    results();
  end
endmodule : sensor_config_status_params_test
